// ==== src/pllr_ctrl.sv ====
// Purpose: reference path control: pump mode, input power, switchover
// Assumes: reference pins are slow enough to sample at 125 MHz
// Notes:   reference validity is a missing-edge timeout on sampled pins
`timescale 1ns/100ps
`include "pllr_map.svh"
module pllr_ctrl (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // register port
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic [7:0]       reg_rdata_o,
   // pins from outside
   input  wire logic        primary_reference_input_i,
   input  wire logic        secondary_reference_input_i,
   input  wire logic        ref_sel_i,
   input  wire logic        sync_n_i,
   // charge pump
   output logic [1:0]       charge_pump_mode_o,
   output logic [2:0]       charge_pump_current_code_o,
   output logic             pfd_polarity_neg_o,
   // reference input power and bias
   output logic             diff_rx_powerdown_o,
   output logic             se1_powerdown_o,
   output logic             se2_powerdown_o,
   output logic             bias_shift_o,
   output logic             crystal_amplifier_enable_o,
   // monitor and switchover
   output logic             reference_monitor_output_o,
   output logic             status_o,
   output logic             active_secondary_o,
   // dividers
   output logic             phase_frequency_detector_ref_o,
   output logic             feedback_counter_reset_o,
   output logic [18:0]      feedback_ratio_o
);
   import pllr_pkg::*;

   pllr_state_t state_ff;
   pllr_state_t nxt_state;
   pllr_div_if  dv ();

   logic pll_pd;
   logic diff_sel;
   logic se1_en;
   logic se2_en;
   logic dual_mode;
   logic deglitch_off;
   logic pref_sec;
   logic pref_bad;
   logic mon_hi;
   logic stat_hi;
   logic trig;
   logic target_sec;
   logic primary_reference_input_now;
   logic secondary_reference_input_now;
   logic primary_reference_input_rise;
   logic secondary_reference_input_rise;
   logic tgt_rise;
   logic sync_evt;
   logic src_on;

   // prescaler code 0..4 maps to 2,4,8,16,32
   function automatic logic [5:0] presc_val(input logic [2:0] code);
      logic [2:0] c;
      c = (code > `PLLR_PRESC_MAX) ? `PLLR_PRESC_MAX : code;
      presc_val = 6'h02 << c;
   endfunction

   function automatic logic [18:0] fb_ratio(input logic [2:0] code,
                                            input logic [12:0] b,
                                            input logic [5:0] a);
      logic [18:0] p;
      p = {13'h0000, presc_val(code)};
      fb_ratio = 19'(p * {6'h00, b}) + {13'h0000, a}; // [RULE21]
   endfunction

   // validity counter: restarts on an edge, times out when edges stop
   function automatic logic [8:0] next_valid(input logic [7:0] cnt,
                                             input logic ok,
                                             input logic rise);
      logic [7:0] c;
      logic       o;
      c = cnt;
      o = ok;
      if (rise) begin
         c = 8'h00;
         o = 1'b1;
      end else if (cnt >= `PLLR_REF_TIMEOUT) begin
         o = 1'b0;
      end else begin
         c = cnt + 8'h01;
      end
      next_valid = {o, c};
   endfunction

   always_comb begin
      // decoded controls
      pll_pd       = (state_ff.pll_ctrl[1:0] != 2'b00);
      diff_sel     = state_ff.sel[0]; // [RULE5]
      se1_en       = state_ff.sel[1];
      se2_en       = state_ff.sel[2];
      pref_sec     = state_ff.sel[3]; // [RULE15]
      deglitch_off = state_ff.sel[7]; // [RULE16]
      dual_mode    = se1_en && se2_en && !diff_sel; // [RULE11]
      primary_reference_input_now     = state_ff.primary_reference_input_sy[1];
      secondary_reference_input_now     = state_ff.secondary_reference_input_sy[1];
      primary_reference_input_rise    = primary_reference_input_now && !state_ff.primary_reference_input_sy[2];
      secondary_reference_input_rise    = secondary_reference_input_now && !state_ff.secondary_reference_input_sy[2];
      // preferred input loses its edges: monitor and status report it
      pref_bad = pref_sec ? !state_ff.secondary_reference_input_ok : !state_ff.primary_reference_input_ok;
      mon_hi   = (state_ff.mon[3:0] == `PLLR_MON_PRIM_BAD) && pref_bad;
      stat_hi  = (state_ff.mon[7:4] == `PLLR_STAT_PRIM_BAD) && pref_bad;
      trig     = state_ff.bias[3] ? stat_hi : mon_hi; // [RULE15]
      if (!dual_mode) begin
         target_sec = se2_en && !se1_en && !diff_sel;
      end else if (state_ff.sel[5]) begin
         // revertive: back to preferred as soon as it is valid again
         target_sec = pref_sec ^ trig; // [RULE14] [RULE17]
      end else if (state_ff.sel[4]) begin
         target_sec = state_ff.rsel_sy[1]; // [RULE12] [RULE24]
      end else begin
         target_sec = state_ff.sel[6]; // [RULE12]
      end
      tgt_rise = target_sec ? secondary_reference_input_rise : primary_reference_input_rise;
      src_on   = !pll_pd && (diff_sel ||
                 (state_ff.active_sec ? se2_en : se1_en)); // [RULE4]
      sync_evt = (state_ff.sync_ctl != 2'b00) &&
                 !state_ff.sync_sy[1]; // [RULE23]

      nxt_state = state_ff;
      // pins pass two flops; the third stage only feeds edge detection
      nxt_state.primary_reference_input_sy = {state_ff.primary_reference_input_sy[1:0], primary_reference_input_i};
      nxt_state.secondary_reference_input_sy = {state_ff.secondary_reference_input_sy[1:0],
                           secondary_reference_input_i};
      nxt_state.rsel_sy = {state_ff.rsel_sy[0], ref_sel_i};
      nxt_state.sync_sy = {state_ff.sync_sy[0], sync_n_i};

      {nxt_state.primary_reference_input_ok, nxt_state.primary_reference_input_cnt} =
         next_valid(state_ff.primary_reference_input_cnt, state_ff.primary_reference_input_ok, primary_reference_input_rise);
      {nxt_state.secondary_reference_input_ok, nxt_state.secondary_reference_input_cnt} =
         next_valid(state_ff.secondary_reference_input_cnt, state_ff.secondary_reference_input_ok, secondary_reference_input_rise);

      // switchover sequencer
      case (state_ff.sw)
         SW_IDLE: begin
            if (target_sec != state_ff.active_sec) begin
               nxt_state.sw = deglitch_off ? SW_WAIT_LOW
                                           : SW_WAIT_EDGE; // [RULE16]
            end
         end
         SW_WAIT_EDGE: begin
            // a silent target stalls here until the target reverts or deglitch is disabled, by design
            if (target_sec == state_ff.active_sec) begin
               nxt_state.sw = SW_IDLE;
            end else if (tgt_rise || deglitch_off) begin
               // disabling deglitch also frees a switch stalled here
               nxt_state.sw = SW_WAIT_LOW; // [RULE13] [RULE16]
            end
         end
         SW_WAIT_LOW: begin
            if (target_sec == state_ff.active_sec) begin
               nxt_state.sw = SW_IDLE;
            end else if (!primary_reference_input_now && !secondary_reference_input_now) begin
               // both low: old pulse complete, new one not begun
               nxt_state.active_sec = target_sec; // [RULE25]
               nxt_state.sw         = SW_IDLE;
            end
         end
         default: begin
            nxt_state.sw = SW_IDLE;
         end
      endcase

      nxt_state.ref_edge = src_on &&
         (state_ff.active_sec && !diff_sel ? secondary_reference_input_rise : primary_reference_input_rise);
      nxt_state.fb_ratio = fb_ratio(state_ff.prescale,
         {state_ff.fb_b_hi, state_ff.fb_b_lo}, state_ff.fb_a);

      // register writes; reset bits stay until written back to zero
      if (reg_wr_i) begin
         case (reg_addr_i)
            `PLLR_A_PLL_CTRL: nxt_state.pll_ctrl = reg_wdata_i; // [RULE1]
            `PLLR_A_RDIV_LO:  nxt_state.rdiv_lo  = reg_wdata_i;
            `PLLR_A_RDIV_HI:  nxt_state.rdiv_hi  = reg_wdata_i[5:0];
            `PLLR_A_FB_A:     nxt_state.fb_a     = reg_wdata_i[5:0];
            `PLLR_A_FB_B_LO:  nxt_state.fb_b_lo  = reg_wdata_i;
            `PLLR_A_FB_B_HI:  nxt_state.fb_b_hi  = reg_wdata_i[4:0];
            `PLLR_A_PRESCALE: nxt_state.prescale = reg_wdata_i[2:0];
            `PLLR_A_BIAS:     nxt_state.bias     = reg_wdata_i; // [RULE6]
            `PLLR_A_SYNC:     nxt_state.sync_ctl = reg_wdata_i[7:6];
            `PLLR_A_MON:      nxt_state.mon      = reg_wdata_i;
            `PLLR_A_SEL:      nxt_state.sel      = reg_wdata_i;
            `PLLR_A_CNT_RST:  nxt_state.cnt_rst  = reg_wdata_i[1:0]; // [RULE22]
            default: begin
            end
         endcase
      end

      // reads answer one cycle later; unmapped reads give zero
      if (reg_rd_i) begin
         case (reg_addr_i)
            `PLLR_A_PLL_CTRL: nxt_state.rdata = state_ff.pll_ctrl;
            `PLLR_A_RDIV_LO:  nxt_state.rdata = state_ff.rdiv_lo;
            `PLLR_A_RDIV_HI:  nxt_state.rdata = {2'b00, state_ff.rdiv_hi};
            `PLLR_A_FB_A:     nxt_state.rdata = {2'b00, state_ff.fb_a};
            `PLLR_A_FB_B_LO:  nxt_state.rdata = state_ff.fb_b_lo;
            `PLLR_A_FB_B_HI:  nxt_state.rdata = {3'b000, state_ff.fb_b_hi};
            `PLLR_A_PRESCALE: nxt_state.rdata = {5'h00, state_ff.prescale};
            `PLLR_A_BIAS:     nxt_state.rdata = state_ff.bias;
            `PLLR_A_SYNC:     nxt_state.rdata = {state_ff.sync_ctl, 6'h00};
            `PLLR_A_MON:      nxt_state.rdata = state_ff.mon;
            `PLLR_A_SEL:      nxt_state.rdata = state_ff.sel;
            `PLLR_A_CNT_RST:  nxt_state.rdata = {state_ff.active_sec,
               state_ff.secondary_reference_input_ok, state_ff.primary_reference_input_ok, 3'b000,
               state_ff.cnt_rst};
            default:          nxt_state.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_ff          <= '0; // [RULE4] [RULE23]
         state_ff.pll_ctrl <= `PLLR_PLL_CTRL_RST;
         state_ff.sw       <= SW_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // divider link
   assign dv.ref_edge  = state_ff.ref_edge;
   assign dv.div_value = {state_ff.rdiv_hi, state_ff.rdiv_lo};
   assign dv.div_clear = state_ff.cnt_rst[0] || state_ff.cnt_rst[1] ||
                         sync_evt; // [RULE20]

   pllr_refdiv u_refdiv (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .dv      (dv)
   );

   // outputs
   assign reg_rdata_o                = state_ff.rdata;
   assign charge_pump_mode_o         = state_ff.pll_ctrl[3:2]; // [RULE1]
   assign charge_pump_current_code_o = state_ff.pll_ctrl[6:4]; // [RULE2]
   assign pfd_polarity_neg_o         = state_ff.pll_ctrl[7];
   assign diff_rx_powerdown_o        = !diff_sel || pll_pd; // [RULE8]
   assign se1_powerdown_o = pll_pd || state_ff.bias[1] || diff_sel ||
                            !se1_en; // [RULE7] [RULE9]
   assign se2_powerdown_o = pll_pd || state_ff.bias[2] || diff_sel ||
                            !se2_en; // [RULE7] [RULE9]
   assign bias_shift_o               = state_ff.bias[7]; // [RULE6]
   assign crystal_amplifier_enable_o = state_ff.bias[0]; // [RULE10]
   assign reference_monitor_output_o = mon_hi; // [RULE14]
   assign status_o                   = stat_hi;
   assign active_secondary_o         = state_ff.active_sec;
   assign phase_frequency_detector_ref_o = dv.pfd_pulse; // [RULE19]
   assign feedback_counter_reset_o   = state_ff.cnt_rst[1] || sync_evt;
   assign feedback_ratio_o           = state_ff.fb_ratio;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   property p_pump_mode;
      reg_wr_i && reg_addr_i == `PLLR_A_PLL_CTRL |=>
         charge_pump_mode_o == $past(reg_wdata_i[3:2]);
   endproperty
   a_pump_mode: assert property (p_pump_mode) // [RULE1]
      else $error("pump mode not taken from write");

   property p_pump_cur;
      reg_wr_i && reg_addr_i == `PLLR_A_PLL_CTRL |=>
         charge_pump_current_code_o == $past(reg_wdata_i[6:4]);
   endproperty
   a_pump_cur: assert property (p_pump_cur) // [RULE2]
      else $error("pump current code wrong");

   property p_bias;
      reg_wr_i && reg_addr_i == `PLLR_A_BIAS |=>
         bias_shift_o == $past(reg_wdata_i[7]);
   endproperty
   a_bias: assert property (p_bias) // [RULE6]
      else $error("bias shift not taken from write");

   property p_diff_pd;
      (!diff_sel || pll_pd) |-> diff_rx_powerdown_o;
   endproperty
   a_diff_pd: assert property (p_diff_pd) // [RULE8]
      else $error("differential receiver powered wrongly");

   property p_se_pd;
      (pll_pd || diff_sel || state_ff.bias[1]) |->
         se1_powerdown_o && (state_ff.bias[1] || se2_powerdown_o);
   endproperty
   a_se_pd: assert property (p_se_pd) // [RULE9]
      else $error("single-ended buffer powered wrongly");

   property p_monitor;
      state_ff.mon == 8'hF7 && state_ff.sel == 8'h26 && !state_ff.primary_reference_input_ok
         |-> reference_monitor_output_o;
   endproperty
   a_monitor: assert property (p_monitor) // [RULE14]
      else $error("monitor pin low while primary invalid");

   property p_clean_switch;
      $changed(state_ff.active_sec) |->
         $past(!primary_reference_input_now && !secondary_reference_input_now);
   endproperty
   a_clean_switch: assert property (p_clean_switch) // [RULE25]
      else $error("switch while a reference was high");

   property p_div_one;
      dv.ref_edge && dv.div_value <= 14'h0001 && !dv.div_clear |=>
         phase_frequency_detector_ref_o;
   endproperty
   a_div_one: assert property (p_div_one) // [RULE18]
      else $error("divide-by-one missed an edge");

   property p_div_clear;
      dv.div_clear |=> !phase_frequency_detector_ref_o;
   endproperty
   a_div_clear: assert property (p_div_clear) // [RULE20]
      else $error("divider pulsed while in reset");

   property p_hold_rst;
      state_ff.cnt_rst[1] && !(reg_wr_i && reg_addr_i == `PLLR_A_CNT_RST)
         |=> feedback_counter_reset_o;
   endproperty
   a_hold_rst: assert property (p_hold_rst) // [RULE22]
      else $error("shared counter reset cleared itself");

   property p_sync_off;
      state_ff.sync_ctl == 2'b00 && state_ff.cnt_rst == 2'b00 |->
         !feedback_counter_reset_o;
   endproperty
   a_sync_off: assert property (p_sync_off) // [RULE23]
      else $error("sync reset acted while disabled");

   property p_fb_ratio;
      $stable(state_ff.prescale) && $stable(state_ff.fb_a) |=>
         feedback_ratio_o == 19'(presc_val($past(state_ff.prescale)) *
            {$past(state_ff.fb_b_hi), $past(state_ff.fb_b_lo)}) +
            {13'h0000, $past(state_ff.fb_a)};
   endproperty
   a_fb_ratio: assert property (p_fb_ratio) // [RULE21]
      else $error("feedback ratio wrong");

   c_to_sec: cover property ($rose(state_ff.active_sec));
   c_back:   cover property ($fell(state_ff.active_sec));
   c_pfd:    cover property (phase_frequency_detector_ref_o);
   c_mon:    cover property ($rose(reference_monitor_output_o));
endmodule

// ==== src/pllr_map.svh ====
// Purpose: offsets, field positions, reset values and counts for pllr
// Assumes: 8-bit registers on a byte-addressed register port
// Notes:   included by the modules
// Overview of operation
// RULE1 - charge pump offers high-z, normal, forced up and forced down modes
// RULE2 - pump current code selects eight steps, 0.6 mA to 4.8 mA
// RULE3 - software calibrates oscillator at setup and after a frequency change
// RULE4 - all reference inputs are off after reset until software enables one
// RULE5 - selection register picks differential, single-ended or crystal input
// RULE6 - the bias-shift bit lowers the single-ended bias point by 140 mV
// RULE7 - each single-ended buffer has its own power-down bit
// RULE8 - differential receiver is off unless selected and the loop is powered
// RULE9 - single-ended buffer off: loop power-down, own bit, differential mode
// RULE10 - crystal enable bit powers the maintaining amplifier on the pin pair
// RULE11 - dual single-ended mode has manual and automatic revertive switching
// RULE12 - manual switchover comes from the selection register or select pin
// RULE13 - software keeps the target toggling or disables deglitching first
// RULE14 - monitor 0xF7 and selection 0x26 switch over on primary validity
// RULE15 - status pin may trigger switchover; secondary may be preferred
// RULE16 - deglitch blocks misaligned edges after a switch; a bit disables it
// RULE17 - only manual and automatic revertive switching; never non-revertive
// RULE18 - 14-bit reference divider; settings zero and one both divide by one
// RULE19 - reference divider output drives the detector's reference input
// RULE20 - divider reset by own bit, shared counter bit, or synchronization
// RULE21 - feedback ratio equals prescaler times B plus A, prescaler 2 to 32
// RULE22 - counter reset bits never clear themselves
// RULE23 - sync pin counter reset uses a two-bit field, disabled after reset
// RULE24 - select pin low picks primary, high secondary, in pin mode
// RULE25 - the divider input switches only where no pulse is cut or added
`ifndef PLLR_MAP_SVH
`define PLLR_MAP_SVH
`define PLLR_A_PLL_CTRL   8'h10
`define PLLR_A_RDIV_LO    8'h11
`define PLLR_A_RDIV_HI    8'h12
`define PLLR_A_FB_A       8'h13
`define PLLR_A_FB_B_LO    8'h14
`define PLLR_A_FB_B_HI    8'h15
`define PLLR_A_PRESCALE   8'h16
`define PLLR_A_BIAS       8'h18
`define PLLR_A_SYNC       8'h19
`define PLLR_A_MON        8'h1B
`define PLLR_A_SEL        8'h1C
`define PLLR_A_CNT_RST    8'h1F
`define PLLR_PLL_CTRL_RST 8'h01
`define PLLR_ZERO_RST     8'h00
`define PLLR_MON_PRIM_BAD 4'h7
`define PLLR_STAT_PRIM_BAD 4'hF
`define PLLR_REF_TIMEOUT  8'h40
`define PLLR_PRESC_MAX    3'h4
`endif

// ==== src/pllr_pkg.sv ====
// Purpose: types shared by the pllr modules
// Assumes: pllr_map.svh holds every number
// Notes:   state structs follow the one-struct-per-module style
package pllr_pkg;
   typedef enum logic [1:0] {
      SW_IDLE, SW_WAIT_EDGE, SW_WAIT_LOW
   } pllr_sw_t;

   typedef struct packed {
      logic [7:0]  pll_ctrl;
      logic [7:0]  rdiv_lo;
      logic [5:0]  rdiv_hi;
      logic [5:0]  fb_a;
      logic [7:0]  fb_b_lo;
      logic [4:0]  fb_b_hi;
      logic [2:0]  prescale;
      logic [7:0]  bias;
      logic [1:0]  sync_ctl;
      logic [7:0]  mon;
      logic [7:0]  sel;
      logic [1:0]  cnt_rst;
      logic [7:0]  rdata;
      logic [2:0]  primary_reference_input_sy;
      logic [2:0]  secondary_reference_input_sy;
      logic [1:0]  rsel_sy;
      logic [1:0]  sync_sy;
      logic [7:0]  primary_reference_input_cnt;
      logic [7:0]  secondary_reference_input_cnt;
      logic        primary_reference_input_ok;
      logic        secondary_reference_input_ok;
      logic        active_sec;
      pllr_sw_t    sw;
      logic        ref_edge;
      logic [18:0] fb_ratio;
   } pllr_state_t;

   typedef struct packed {
      logic [13:0] cnt;
      logic        pulse;
   } pllr_div_state_t;
endpackage

// ==== src/pllr_div_if.sv ====
// Purpose: carries reference edges and divider control to the divider
// Assumes: one clock domain
// Notes:   ctrl drives, div answers with one pulse per division
`timescale 1ns/100ps
interface pllr_div_if;
   logic        ref_edge;
   logic [13:0] div_value;
   logic        div_clear;
   logic        pfd_pulse;
   modport ctrl (output ref_edge, output div_value, output div_clear,
                 input pfd_pulse);
   modport div  (input ref_edge, input div_value, input div_clear,
                 output pfd_pulse);
endinterface

// ==== src/pllr_refdiv.sv ====
// Purpose: 14-bit reference divider feeding the detector reference input
// Assumes: ref_edge is a one-cycle pulse per selected reference edge
// Notes:   clear holds the count at zero for as long as it stays high
`timescale 1ns/100ps
`include "pllr_map.svh"
module pllr_refdiv (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   // divider link
   pllr_div_if.div   dv
);
   import pllr_pkg::*;
   pllr_div_state_t state_ff;
   pllr_div_state_t nxt_state;
   logic [13:0]     last;

   always_comb begin
      nxt_state = state_ff;
      // zero and one both give divide-by-one
      last = (dv.div_value == 14'h0000) ? 14'h0000
                                         : dv.div_value - 14'h0001; // [RULE18]
      nxt_state.pulse = 1'b0;
      if (dv.div_clear) begin
         nxt_state.cnt = 14'h0000; // [RULE20]
      end else if (dv.ref_edge) begin
         if (state_ff.cnt >= last) begin
            nxt_state.cnt   = 14'h0000;
            nxt_state.pulse = 1'b1; // [RULE18]
         end else begin
            nxt_state.cnt = state_ff.cnt + 14'h0001;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign dv.pfd_pulse = state_ff.pulse; // [RULE19]
endmodule

// ==== sim/pllr_refsrc.sv ====
// Purpose: reference clock sources seen by the pllr reference pins
// Assumes: half period given in whole clk_i cycles, at least two
// Notes:   a stopped source parks low, like an idle dc-coupled driver
`timescale 1ns/100ps
module pllr_refsrc (
   // clock
   input  wire logic       clk_i,
   // bench control
   input  wire logic       run1_i,
   input  wire logic       run2_i,
   input  wire logic [3:0] half_i,
   // reference pins
   output logic            primary_reference_input_o,
   output logic            secondary_reference_input_o
);
   logic [3:0] cnt_ff = 4'h0;

   initial begin
      primary_reference_input_o = 1'b0;
      secondary_reference_input_o = 1'b0;
   end

   // offset phases so the two inputs never toggle together
   always @(posedge clk_i) begin
      cnt_ff <= (cnt_ff >= half_i - 4'h1) ? 4'h0 : cnt_ff + 4'h1;
      // target keeps toggling unless a scenario stops it
      primary_reference_input_o <= run1_i & ((cnt_ff == 4'h0) ? ~primary_reference_input_o : primary_reference_input_o);
      secondary_reference_input_o <= run2_i & ((cnt_ff == 4'h1) ? ~secondary_reference_input_o : secondary_reference_input_o);
   end
endmodule

// ==== sim/pll_reference_path_control_test.sv ====
// Purpose: self-checking bench for pllr_ctrl
// Assumes: reference period of eight clk_i cycles from pllr_refsrc
// Notes:   reads are scored by a monitor from a queue of expectations
`timescale 1ns/100ps
module pll_reference_path_control_test;
   logic clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
   logic ref_sel_i = 1'b0, sync_n_i = 1'b1, run1 = 1'b1, run2 = 1'b1;
   logic primary_reference_input_i, secondary_reference_input_i;
   logic [1:0] charge_pump_mode_o;
   logic [2:0] charge_pump_current_code_o;
   logic pfd_polarity_neg_o, diff_rx_powerdown_o, se1_powerdown_o;
   logic se2_powerdown_o, bias_shift_o, crystal_amplifier_enable_o;
   logic reference_monitor_output_o, status_o, active_secondary_o;
   logic phase_frequency_detector_ref_o, feedback_counter_reset_o;
   logic [18:0] feedback_ratio_o;
   logic [7:0] exp_q[$];
   logic rd_q = 1'b0;
   int n_fail = 0, comparisons = 0;

   always #4 clk_i = ~clk_i;

   pllr_ctrl pllr_ctrl_inst (.clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i,
      .reg_wr_i, .reg_rd_i, .reg_rdata_o, .primary_reference_input_i,
      .secondary_reference_input_i, .ref_sel_i, .sync_n_i,
      .charge_pump_mode_o, .charge_pump_current_code_o, .pfd_polarity_neg_o,
      .diff_rx_powerdown_o, .se1_powerdown_o, .se2_powerdown_o,
      .bias_shift_o, .crystal_amplifier_enable_o,
      .reference_monitor_output_o, .status_o, .active_secondary_o,
      .phase_frequency_detector_ref_o, .feedback_counter_reset_o,
      .feedback_ratio_o);
   pllr_refsrc pllr_refsrc_inst (.clk_i, .run1_i(run1), .run2_i(run2),
      .half_i(4'h4), .primary_reference_input_o(primary_reference_input_i),
      .secondary_reference_input_o(secondary_reference_input_i));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic summarize;
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic tick;
      @(posedge clk_i);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      tick;
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      tick;
      reg_wr_i = 1'b0;
   endtask

   // expectation noted here, scored by the monitor below
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      tick;
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      exp_q.push_back(e);
      tick;
      reg_rd_i = 1'b0;
   endtask

   always @(posedge clk_i) begin
      if (rd_q && exp_q.size() > 0) check(reg_rdata_o, exp_q.pop_front());
      rd_q <= reg_rd_i;
   end

   task automatic wait_sec(input logic v);
      int i;
      for (i = 0; i < 400 && active_secondary_o !== v; i++) tick;
      check(active_secondary_o, v);
   endtask

   // cycles to the next detector pulse; 3000 means none came
   task automatic pfd_gap(output int g);
      g = 0;
      do begin
         tick;
         g++;
      end while (phase_frequency_detector_ref_o !== 1'b1 && g < 3000);
   endtask

   initial begin
      logic [7:0] s, b;
      logic [2:0] c;
      logic [5:0] a;
      logic [12:0] bb;
      logic [1:0] p;
      logic [13:0] rv[4];
      int g;
      rv = '{14'd258, 14'd0, 14'd1, 14'd3};
      void'($urandom(32'h23fa));
      repeat (16) @(posedge clk_i);
      #1 rst_n_i = 1'b1;
      check(diff_rx_powerdown_o & se1_powerdown_o & se2_powerdown_o, 1);
      rd(8'h10, 8'h01);
      rd(8'h1C, 8'h00);
      rd(8'h19, 8'h00);
      rd(8'h30, 8'h00);
      for (int m = 0; m < 4; m++) begin
         c = 3'($urandom_range(7));
         wr(8'h10, {c[0], c, m[1:0], 2'b00});
         check(charge_pump_mode_o, m[1:0]);
         check(pfd_polarity_neg_o, c[0]);
         check(charge_pump_current_code_o, c);
      end
      for (int k = 0; k < 8; k++) begin
         s = 8'($urandom_range(7));
         b = 8'($urandom) & 8'h87;
         p = 2'($urandom_range(1));
         wr(8'h10, {6'h00, p});
         wr(8'h18, b);
         wr(8'h1C, s);
         check(diff_rx_powerdown_o, !s[0] | (p != 2'b00));
         check(se1_powerdown_o, (p != 2'b00) | b[1] | s[0] | !s[1]);
         check(se2_powerdown_o, (p != 2'b00) | b[2] | s[0] | !s[2]);
         check(bias_shift_o, b[7]);
         check(crystal_amplifier_enable_o, b[0]);
         rd(8'h1C, s);
      end
      for (int k = 0; k < 6; k++) begin
         a = 6'($urandom);
         bb = 13'($urandom);
         wr(8'h13, {2'b00, a});
         wr(8'h14, bb[7:0]);
         wr(8'h15, {3'b000, bb[12:8]});
         wr(8'h16, 8'(k)); // new ratio: a recalibration point
         tick;
         check(feedback_ratio_o, 19'((32'd2 << (k > 4 ? 4 : k)) * bb + a));
      end
      wr(8'h10, 8'h04);
      wr(8'h18, 8'h00);
      wr(8'h1C, 8'h02);
      foreach (rv[k]) begin
         wr(8'h11, rv[k][7:0]);
         wr(8'h12, {2'b00, rv[k][13:8]});
         pfd_gap(g);
         pfd_gap(g);
         check(g, 8 * (rv[k] < 2 ? 1 : rv[k]));
      end
      wr(8'h1F, 8'h01);
      repeat (3) tick;
      pfd_gap(g);
      check(g, 3000);
      wr(8'h1F, 8'h02);
      check(feedback_counter_reset_o, 1);
      wr(8'h1F, 8'h00);
      pfd_gap(g);
      pfd_gap(g);
      check(g, 24);
      sync_n_i = 1'b0;
      repeat (4) tick;
      check(feedback_counter_reset_o, 0);
      wr(8'h19, 8'h40);
      repeat (3) tick;
      check(feedback_counter_reset_o, 1);
      sync_n_i = 1'b1;
      wr(8'h1C, 8'h06);
      repeat (100) tick;
      wr(8'h1C, 8'h46);
      wait_sec(1);
      wr(8'h1C, 8'h16);
      wait_sec(0);
      ref_sel_i = 1'b1;
      wait_sec(1);
      ref_sel_i = 1'b0;
      wait_sec(0);
      // target stopped: deglitch must hold the switch off
      run2 = 1'b0;
      wr(8'h1C, 8'h46);
      repeat (200) tick;
      check(active_secondary_o, 0);
      wr(8'h1C, 8'hC6);
      wait_sec(1);
      wr(8'h1C, 8'h06);
      wait_sec(0);
      run2 = 1'b1;
      wr(8'h1B, 8'hF7);
      wr(8'h1C, 8'h26);
      run1 = 1'b0;
      wait_sec(1);
      check(reference_monitor_output_o, 1);
      run1 = 1'b1;
      wait_sec(0);
      check(reference_monitor_output_o, 0);
      wr(8'h18, 8'h08);
      run1 = 1'b0;
      wait_sec(1);
      check(status_o, 1);
      run1 = 1'b1;
      wait_sec(0);
      wr(8'h1C, 8'h2E);
      wait_sec(1);
      run2 = 1'b0;
      wait_sec(0);
      repeat (2) tick;
      summarize();
   end

   initial begin
      #400_000;
      n_fail++;
      summarize();
   end
endmodule
